// ### gcr_pkg.sv
// Purpose: constants and state layout for the g832 receive overhead status bank
// Assumes: 16-bit register port, word offsets as printed
// Notes: one package, no imports
// What this block does
// R1: a latched remote error raises the interrupt only with enable bit 10 and the port enable set.
// R2: a latched parity error raises the interrupt only with enable bit 9 and the port enable set.
// R3: a latched framing error raises the interrupt only with enable bit 8 and the port enable set.
// R4: a latched remote error count flag raises the interrupt only with bit 2 and the port enable.
// R5: a latched parity error count flag raises the interrupt only with bit 1 and the port enable.
// R6: a latched framing error count flag raises the interrupt only with bit 0 and the port enable.
// R7: bits 6 to 4 of the ma byte status show the integrated payload type from ma bits 3 to 5.
// R8: with timing extraction on, bits 3 to 0 show the integrated four-bit timing indicator.
// R9: with timing extraction off, bit 3 reads zero and bits 2 to 0 show the last three ma bits.
// R10: bits 15 to 8 of the overhead byte register show the integrated gc byte.
// R11: bits 7 to 0 of the overhead byte register show the integrated nr byte.
// R12: detected parity, framing and remote errors set their latched flags.
// R13: each latched count flag sets when its count-nonzero indication rises from zero to one.
// R14: a sixteen-bit framing error count register is loaded on the monitoring update strobe.
// R15: a latched change flag sets whenever the integrated gc byte changes.
// R16: an integrated field only takes a new value seen in several consecutive frames.
package gcr_pkg;
    localparam logic [9:0] GCR_OFS_ERR_IRQ_EN2 = 10'h12e;
    localparam logic [9:0] GCR_OFS_MA_STATUS = 10'h130;
    localparam logic [9:0] GCR_OFS_NR_GC = 10'h132;
    localparam logic [9:0] GCR_OFS_FE_COUNT = 10'h134;
    localparam logic [9:0] GCR_OFS_ERR_LATCHED = 10'h12a;
    localparam logic [9:0] GCR_OFS_GC_LATCHED = 10'h128;
    localparam logic [9:0] GCR_OFS_CTRL = 10'h13a;
    localparam logic [15:0] GCR_RST_WORD = 16'h0000;
    localparam logic [15:0] GCR_ERR_IRQ_EN2_MASK = 16'h0707;
    localparam int GCR_BIT_REMOTE = 10;
    localparam int GCR_BIT_PARITY = 9;
    localparam int GCR_BIT_FRAMING = 8;
    localparam int GCR_BIT_REMOTE_CNT = 2;
    localparam int GCR_BIT_PARITY_CNT = 1;
    localparam int GCR_BIT_FRAMING_CNT = 0;
    localparam int GCR_BIT_GC_CHANGE = 7;
    localparam int GCR_BIT_TI_EXTRACT = 0;
    localparam int GCR_BIT_PORT_IRQ_EN = 1;
    localparam logic [2:0] GCR_INTEG_FRAMES = 3'h5;

    typedef struct packed {
        logic [15:0] irq_en2_r;
        logic [15:0] err_latched_r;
        logic gc_change_latched_r;
        logic ti_extract_en_r;
        logic port_status_irq_enable_r;
        logic [15:0] fe_count_r;
        logic [15:0] fe_running_r;
        logic [2:0] cnt_nonzero_d_r;
        logic [15:0] rd_data_r;
        logic irq_r;
    } gcr_state_t;
endpackage : gcr_pkg

// ### gcr_integ.sv
// Purpose: persistence filter for one received overhead field
// Assumes: sample_i pulses once per received frame
// Notes: width set per instance
`timescale 1ns/10ps
module gcr_integ #(
    parameter int W = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic sample_i,
    input wire logic [W-1:0] value_i,
    output logic [W-1:0] value_o
);
    typedef struct packed {
        logic [W-1:0] cand_r;
        logic [2:0] run_r;
        logic [W-1:0] value_r;
    } gcr_integ_t;
    gcr_integ_t st_r;
    gcr_integ_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (sample_i) begin
            if (value_i != st_r.cand_r) begin
                st_nxt.cand_r = value_i;
                st_nxt.run_r = 3'h1;
            end else if (st_r.run_r < gcr_pkg::GCR_INTEG_FRAMES) begin
                st_nxt.run_r = st_r.run_r + 3'h1;
            end
            // only a run of equal frames moves the output, see R16
            if (value_i == st_r.cand_r && st_r.run_r + 3'h1 >= gcr_pkg::GCR_INTEG_FRAMES) begin
                st_nxt.value_r = value_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value_o = st_r.value_r;
endmodule : gcr_integ

// ### gcr_top.sv
// Purpose: g832 receive overhead status registers and error interrupt
// Assumes: framer inputs are on sys_clk_i, one-cycle event pulses
// Notes: read data valid the cycle after the read strobe
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module gcr_top (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [9:0] addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rd_data_o,
    output logic irq_o,
    input wire logic frame_i,
    input wire logic [7:0] ma_byte_i,
    input wire logic [3:0] ti_bits_i,
    input wire logic [7:0] nr_byte_i,
    input wire logic [7:0] gc_byte_i,
    input wire logic parity_err_i,
    input wire logic framing_err_i,
    input wire logic remote_err_i,
    input wire logic remote_err_count_nonzero_i,
    input wire logic parity_err_count_nonzero_i,
    input wire logic framing_err_count_nonzero_i,
    input wire logic perf_monitor_update_strobe_i
);
    gcr_pkg::gcr_state_t st_r;
    gcr_pkg::gcr_state_t st_nxt;
    logic [2:0] rx_payload_type;
    logic [3:0] ti_integ;
    logic [2:0] ma_tail_integ;
    logic [7:0] rx_nr_byte;
    logic [7:0] rx_gc_byte;
    logic [7:0] gc_prev_r;
    logic [3:0] rx_timing_source_ind;
    logic [15:0] set_bits;
    logic [15:0] clr_bits;
    logic [2:0] cnt_nonzero;
    logic gc_clr;

    // ma bit 1 is the msb, so positions 3..5 are bits 5..3
    gcr_integ #(.W(3)) u_pt (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .sample_i(frame_i),
        .value_i(ma_byte_i[5:3]),
        .value_o(rx_payload_type)
    ); // see R7
    gcr_integ #(.W(4)) u_ti (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .sample_i(frame_i),
        .value_i(ti_bits_i),
        .value_o(ti_integ)
    ); // see R8
    gcr_integ #(.W(3)) u_tail (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .sample_i(frame_i),
        .value_i(ma_byte_i[2:0]),
        .value_o(ma_tail_integ)
    ); // see R9
    gcr_integ #(.W(8)) u_nr (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .sample_i(frame_i),
        .value_i(nr_byte_i),
        .value_o(rx_nr_byte)
    ); // see R11
    gcr_integ #(.W(8)) u_gc (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .sample_i(frame_i),
        .value_i(gc_byte_i),
        .value_o(rx_gc_byte)
    ); // see R10

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            gc_prev_r <= 8'h00;
        end else begin
            gc_prev_r <= rx_gc_byte;
        end
    end

    always_comb begin
        // timing bits come from the integrated ti_bits_i with extraction on, else from the integrated ma tail
        if (st_r.ti_extract_en_r) begin
            rx_timing_source_ind = ti_integ; // see R8
        end else begin
            rx_timing_source_ind = {1'b0, ma_tail_integ}; // see R9
        end
    end

    assign cnt_nonzero = {remote_err_count_nonzero_i, parity_err_count_nonzero_i,
                          framing_err_count_nonzero_i};

    always_comb begin
        st_nxt = st_r;
        set_bits = 16'h0000;
        clr_bits = 16'h0000;
        gc_clr = 1'b0;
        st_nxt.cnt_nonzero_d_r = cnt_nonzero;
        set_bits[gcr_pkg::GCR_BIT_PARITY] = parity_err_i; // see R12
        set_bits[gcr_pkg::GCR_BIT_FRAMING] = framing_err_i; // see R12
        set_bits[gcr_pkg::GCR_BIT_REMOTE] = remote_err_i; // see R12
        // rising edge of each count-nonzero level, see R13
        set_bits[gcr_pkg::GCR_BIT_REMOTE_CNT] = cnt_nonzero[2] & ~st_r.cnt_nonzero_d_r[2];
        set_bits[gcr_pkg::GCR_BIT_PARITY_CNT] = cnt_nonzero[1] & ~st_r.cnt_nonzero_d_r[1];
        set_bits[gcr_pkg::GCR_BIT_FRAMING_CNT] = cnt_nonzero[0] & ~st_r.cnt_nonzero_d_r[0];
        if (wr_i) begin
            case (addr_i)
                gcr_pkg::GCR_OFS_ERR_IRQ_EN2: begin
                    st_nxt.irq_en2_r = wr_data_i & gcr_pkg::GCR_ERR_IRQ_EN2_MASK;
                end
                gcr_pkg::GCR_OFS_ERR_LATCHED: begin
                    clr_bits = wr_data_i & gcr_pkg::GCR_ERR_IRQ_EN2_MASK;
                end
                gcr_pkg::GCR_OFS_GC_LATCHED: begin
                    gc_clr = wr_data_i[gcr_pkg::GCR_BIT_GC_CHANGE];
                end
                gcr_pkg::GCR_OFS_CTRL: begin
                    st_nxt.ti_extract_en_r = wr_data_i[gcr_pkg::GCR_BIT_TI_EXTRACT];
                    st_nxt.port_status_irq_enable_r = wr_data_i[gcr_pkg::GCR_BIT_PORT_IRQ_EN];
                end
                default: begin
                end
            endcase
        end
        // set wins over a clear in the same cycle
        st_nxt.err_latched_r = ((st_r.err_latched_r & ~clr_bits) | set_bits)
                               & gcr_pkg::GCR_ERR_IRQ_EN2_MASK;
        st_nxt.gc_change_latched_r = (st_r.gc_change_latched_r & ~gc_clr)
                                     | (rx_gc_byte != gc_prev_r); // see R15
        // running count is copied out on the update strobe, see R14
        if (perf_monitor_update_strobe_i) begin
            // the event on the strobe cycle still counts, but never wraps past ffff
            st_nxt.fe_count_r = st_r.fe_running_r;
            if (framing_err_i && st_r.fe_running_r != 16'hffff) begin
                st_nxt.fe_count_r = st_r.fe_running_r + 16'h0001;
            end
            st_nxt.fe_running_r = 16'h0000;
        end else if (framing_err_i && st_r.fe_running_r != 16'hffff) begin
            st_nxt.fe_running_r = st_r.fe_running_r + 16'h0001;
        end
        st_nxt.rd_data_r = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                gcr_pkg::GCR_OFS_ERR_IRQ_EN2: begin
                    st_nxt.rd_data_r = st_r.irq_en2_r;
                end
                gcr_pkg::GCR_OFS_ERR_LATCHED: begin
                    st_nxt.rd_data_r = st_r.err_latched_r;
                end
                gcr_pkg::GCR_OFS_GC_LATCHED: begin
                    st_nxt.rd_data_r[gcr_pkg::GCR_BIT_GC_CHANGE] = st_r.gc_change_latched_r;
                end
                gcr_pkg::GCR_OFS_CTRL: begin
                    st_nxt.rd_data_r[gcr_pkg::GCR_BIT_TI_EXTRACT] = st_r.ti_extract_en_r;
                    st_nxt.rd_data_r[gcr_pkg::GCR_BIT_PORT_IRQ_EN] =
                        st_r.port_status_irq_enable_r;
                end
                gcr_pkg::GCR_OFS_MA_STATUS: begin
                    st_nxt.rd_data_r = {9'h000, rx_payload_type, rx_timing_source_ind}; // see R7
                end
                gcr_pkg::GCR_OFS_NR_GC: begin
                    st_nxt.rd_data_r = {rx_gc_byte, rx_nr_byte}; // see R10 see R11
                end
                gcr_pkg::GCR_OFS_FE_COUNT: begin
                    st_nxt.rd_data_r = st_r.fe_count_r; // see R14
                end
                default: begin
                end
            endcase
        end
        // enable bits line up with latched bits, see R1 R2 R3 R4 R5 R6
        st_nxt.irq_r = st_r.port_status_irq_enable_r
                       && ((st_r.err_latched_r & st_r.irq_en2_r) != 16'h0000);
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_o = st_r.rd_data_r;
    assign irq_o = st_r.irq_r;
endmodule : gcr_top

// ### gcr_asserts.sv
// Purpose: port checks for the overhead status bank
// Assumes: bound to gcr_top, enable writes shadowed here
// Notes: latched flags are not visible, so irq is judged against the shadow enables
`timescale 1ns/10ps
module gcr_asserts (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [9:0] addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rd_data_o,
    input wire logic irq_o,
    input wire logic parity_err_i,
    input wire logic remote_err_i,
    input wire logic framing_err_count_nonzero_i
);
    localparam logic [9:0] EN = gcr_pkg::GCR_OFS_ERR_IRQ_EN2;
    logic [15:0] en_r;
    logic pe_r;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            en_r <= 16'h0000;
            pe_r <= 1'h0;
        end else if (wr_i && addr_i == EN) begin
            en_r <= wr_data_i & gcr_pkg::GCR_ERR_IRQ_EN2_MASK;
        end else if (wr_i && addr_i == gcr_pkg::GCR_OFS_CTRL) begin
            pe_r <= wr_data_i[gcr_pkg::GCR_BIT_PORT_IRQ_EN];
        end
    end
    ma_top_zero_a: assert property ($past(rd_i && addr_i == gcr_pkg::GCR_OFS_MA_STATUS)
        |-> rd_data_o[15:7] == 9'h000) else $error("ma status upper bits set");
    en_rsvd_zero_a: assert property ($past(rd_i && addr_i == EN)
        |-> (rd_data_o & 16'hf8f8) == 16'h0000) else $error("enable reserved bits set");
    en_readback_a: assert property ($past(rd_i && addr_i == EN)
        |-> rd_data_o == $past(en_r)) else $error("enable readback wrong");
    irq_gate_a: assert property (irq_o |-> $past(pe_r) && $past(en_r) != 16'h0000)
        else $error("irq without enables");
    remote_irq_a: assert property (remote_err_i && en_r[10] && pe_r |-> ##[1:3] irq_o)
        else $error("remote error irq missing");
    parity_irq_a: assert property (parity_err_i && en_r[9] && pe_r |-> ##[1:3] irq_o)
        else $error("parity error irq missing");
    count_irq_a: assert property ($rose(framing_err_count_nonzero_i) && en_r[0] && pe_r
        |-> ##[1:3] irq_o) else $error("count flag irq missing");
    irq_drop_a: assert property ($fell(pe_r) |-> ##1 !irq_o)
        else $error("irq stays after port disable");
endmodule : gcr_asserts
bind gcr_top gcr_asserts chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
    .parity_err_i(parity_err_i), .remote_err_i(remote_err_i),
    .framing_err_count_nonzero_i(framing_err_count_nonzero_i));

// ### gcr_top_test.sv
// Purpose: self-checking bench for the overhead status bank
// Assumes: read data one cycle after the strobe, irq lags enables by a cycle
// Notes: seeded random overhead bytes
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module gcr_top_test;
    localparam logic [9:0] EN = gcr_pkg::GCR_OFS_ERR_IRQ_EN2;
    localparam logic [9:0] MA = gcr_pkg::GCR_OFS_MA_STATUS;
    localparam logic [9:0] NG = gcr_pkg::GCR_OFS_NR_GC;
    localparam logic [9:0] FC = gcr_pkg::GCR_OFS_FE_COUNT;
    localparam logic [9:0] CT = gcr_pkg::GCR_OFS_CTRL;
    logic sys_clk_i = '0, reset_i = '1, wr_i = '0, rd_i = '0, frame_i = '0, perf_monitor_update_strobe = '0;
    logic perr = '0, ferr = '0, rerr = '0, rd_seen = '0, irq_o, ei;
    logic [9:0] addr_i = '0;
    logic [15:0] wr_data_i = '0, rd_data_o, e;
    logic [7:0] ma = '0, nr = '0, gc = '0;
    logic [3:0] ti = '0;
    logic [2:0] cnz = '0; // remote, parity, framing count-nonzero levels
    logic [15:0] rq[$];
    logic iq[$];
    int err_count = 0, samples_checked = 0;
    integer seed = 32'h056b_25c2;
    gcr_top uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
        .frame_i(frame_i), .ma_byte_i(ma), .ti_bits_i(ti), .nr_byte_i(nr), .gc_byte_i(gc),
        .parity_err_i(perr), .framing_err_i(ferr), .remote_err_i(rerr),
        .remote_err_count_nonzero_i(cnz[2]), .parity_err_count_nonzero_i(cnz[1]),
        .framing_err_count_nonzero_i(cnz[0]), .perf_monitor_update_strobe_i(perf_monitor_update_strobe));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (rd_seen) begin
            e = rq.pop_front();
            `CHK("rd_data_o", e, rd_data_o)
        end
        if (iq.size() > 0) begin
            ei = iq.pop_front();
            `CHK("irq_o", ei, irq_o)
        end
        rd_seen = rd_i;
    end
    task automatic conclude();
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'h1;
        @(posedge sys_clk_i);
        wr_i <= 1'h0;
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [15:0] x);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge sys_clk_i);
        rd_i <= 1'h0;
        rq.push_back(x);
    endtask : rd
    // pushed after the edge so the monitor judges the following edge
    task automatic xi(input logic x);
        @(posedge sys_clk_i);
        #1 iq.push_back(x);
    endtask : xi
    task automatic frames(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            frame_i <= 1'h1;
            @(posedge sys_clk_i);
            frame_i <= 1'h0;
        end
    endtask : frames
    task automatic ev(input int b);
        @(posedge sys_clk_i);
        case (b)
            10: rerr <= 1'h1;
            9: perr <= 1'h1;
            8: ferr <= 1'h1;
            default: cnz[b] <= 1'h1;
        endcase
        @(posedge sys_clk_i);
        {rerr, perr, ferr, cnz} <= '0;
    endtask : ev
    task automatic strobe();
        @(posedge sys_clk_i);
        perf_monitor_update_strobe <= 1'h1;
        @(posedge sys_clk_i);
        perf_monitor_update_strobe <= 1'h0;
    endtask : strobe
    initial begin
        static logic [9:0] ra[5] = '{EN, MA, NG, FC, 10'h3ff};
        static int bits[6] = '{10, 9, 8, 2, 1, 0};
        logic [15:0] n;
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'h0;
        foreach (ra[i]) rd(ra[i], 16'h0000);
        wr(EN, 16'hffff);
        rd(EN, 16'h0707);
        for (int p = 0; p < 2; p++) begin
            wr(CT, p ? 16'h0002 : 16'h0003);
            ma <= 8'($random(seed));
            ti <= 4'($random(seed));
            nr <= 8'($random(seed));
            gc <= 8'($random(seed)) | 8'h01;
            frames(4);
            if (p == 0) rd(MA, 16'h0000);
            frames(1);
            rd(MA, {9'h000, ma[5:3], p ? {1'h0, ma[2:0]} : ti});
            rd(NG, {gc, nr});
        end
        rd(gcr_pkg::GCR_OFS_GC_LATCHED, 16'h0080);
        wr(CT, 16'h0003);
        foreach (bits[i]) begin
            wr(EN, 16'h0001 << bits[i]);
            ev(bits[i]);
            repeat (2) @(posedge sys_clk_i);
            xi(1'h1);
            wr(CT, 16'h0001);
            xi(1'h0);
            wr(CT, 16'h0003);
            xi(1'h1);
            wr(EN, 16'h0000);
            xi(1'h0);
            rd(gcr_pkg::GCR_OFS_ERR_LATCHED, 16'h0001 << bits[i]);
            wr(gcr_pkg::GCR_OFS_ERR_LATCHED, 16'h0001 << bits[i]);
            wr(EN, 16'h0001 << bits[i]);
            xi(1'h0);
        end
        strobe();
        n = 16'h0001 + 16'($random(seed) & 32'h0000_0007);
        repeat (n) ev(8);
        strobe();
        rd(FC, n);
        repeat (3) @(posedge sys_clk_i);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_count++;
        conclude();
    end
endmodule : gcr_top_test
